/* fec_tx_chain.v */
// Purpose: transmit fec chain: scrambler, rs, convolutional code, repetition,
//          two-step interleaver and differential phase mapper
// Assumes: single clock mclk_in, byte source and mapper sink on the same clock
// Notes: one frame part (control header or payload) per start command
//
// The implementer's own choices: the address map and the plain strobed port.
`timescale 1ns/1ns
`include "fec_tx_defs.vh"
module fec_tx_chain (
	// clock and reset
	input wire mclk_in,
	input wire rst_n_in,
	// register port
	input wire [3:0] reg_addr_in,
	input wire [31:0] reg_wdata_in,
	input wire reg_wr_in,
	input wire reg_rd_in,
	output reg [31:0] reg_rdata_out,
	// scrambler-side byte source
	input wire byte_valid_in,
	input wire [7:0] byte_in,
	input wire byte_last_in,
	output wire byte_ready_out,
	// mapper output toward the modulator
	output reg map_valid_out,
	output reg [4:0] map_carrier_out,
	output reg [2:0] map_phase_out,
	input wire map_ready_in
);
	// ----------------------------------------
	// states
	// ----------------------------------------
	localparam S_IDLE = 6'b000001;
	localparam S_IN = 6'b000010;
	localparam S_BITS = 6'b000100;
	localparam S_NEXT = 6'b001000;
	localparam S_PAD = 6'b010000;
	localparam S_OUT = 6'b100000;

	// ----------------------------------------
	// field arithmetic and helpers
	// ----------------------------------------
	// multiply in gf(2^8), reducing by the field polynomial
	function [7:0] gf_mul(input [7:0] a, input [7:0] b);
		integer k;
		reg [7:0] r;
		reg [7:0] x;
		reg [8:0] y;
		begin
			r = 8'h00;
			x = a;
			for (k = 0; k < 8; k = k + 1)
			begin
				if (b[k])
					r = r ^ x;
				// the ninth bit is cleared by the polynomial's top term
				y = {x, 1'b0} ^ ({9{x[7]}} & `FIELD_POLY);
				x = y[7:0];
			end
			gf_mul = r;
		end
	endfunction

	// generator coefficients g0..g(2t-1), top-aligned in 16 byte slots
	function [127:0] gen_poly(input [4:0] nt);
		integer i;
		integer k;
		reg [135:0] p;
		reg [7:0] al;
		begin
			p = 136'h1;
			al = 8'h01;
			gen_poly = 128'h0;
			for (i = 1; i <= nt; i = i + 1)
			begin
				al = gf_mul(al, 8'h02);
				for (k = 16; k >= 1; k = k - 1)
					p[8*k +: 8] = p[8*(k-1) +: 8] ^ gf_mul(al, p[8*k +: 8]);
				p[7:0] = gf_mul(al, p[7:0]);
			end
			for (k = 0; k < nt; k = k + 1)
				gen_poly[8*(16-nt+k) +: 8] = p[8*k +: 8];
		end
	endfunction

	// scramble one byte msb first; returns {next state, scrambled byte}
	function [14:0] scramble(input [7:0] d, input [6:0] s);
		integer k;
		reg [6:0] st;
		reg [7:0] b;
		reg o;
		begin
			st = s;
			b = 8'h00;
			for (k = 7; k >= 0; k = k - 1)
			begin
				o = st[6] ^ st[3];
				b[k] = d[k] ^ o;
				st = {st[5:0], o};
			end
			scramble = {st, b};
		end
	endfunction

	// euclid, bounded loop; true when gcd is one
	function coprime(input [7:0] a, input [7:0] b);
		integer k;
		reg [7:0] x;
		reg [7:0] y;
		reg [7:0] t;
		begin
			x = a;
			y = b;
			for (k = 0; k < 14; k = k + 1)
			begin
				if (y != 8'h00)
				begin
					t = x % y;
					x = y;
					y = t;
				end
			end
			coprime = (x == 8'h01);
		end
	endfunction

	localparam [127:0] GEN_NORMAL = gen_poly(`RS_2T_NORMAL);
	localparam [127:0] GEN_ROBUST = gen_poly(`RS_2T_ROBUST);

	// ----------------------------------------
	// registers and state
	// ----------------------------------------
	reg [4:0] ctrl;
	reg [15:0] matrix;
	reg [31:0] shifts;
	reg [31:0] tones;
	reg done;
	reg [5:0] state;
	reg [6:0] scr;
	reg [127:0] par;
	reg [127:0] next_par;
	reg [7:0] cur_byte;
	reg [3:0] bits_left;
	reg [5:0] cs;
	reg pair;
	reg [2:0] rep;
	reg in_par;
	reg in_tail;
	reg src_last;
	reg [7:0] data_cnt;
	reg [4:0] par_left;
	reg [7:0] wi;
	reg [7:0] wj;
	reg wr_full;
	reg [15:0] rd_ptr;
	reg [4:0] car;
	reg [1:0] mcnt;
	reg [2:0] acc;
	reg [2:0] vsym;
	reg [2:0] delta;
	reg il_mem [0:`IL_DEPTH-1];
	reg [2:0] ph [0:`NUM_CARRIERS-1];
	integer c;
	integer pc;

	wire [7:0] rows = matrix[7:0];
	wire [7:0] cols = matrix[15:8];
	wire [7:0] mi = shifts[7:0];
	wire [7:0] mj = shifts[15:8];
	wire [7:0] ni = shifts[23:16];
	wire [7:0] nj = shifts[31:24];
	wire [15:0] total = rows * cols;
	wire frame_control_header = ~ctrl[`CTRL_PART];
	wire robust = ctrl[`CTRL_ROBUST];
	wire [1:0] modsel = ctrl[`CTRL_MOD_HI:`CTRL_MOD_LO];
	wire [7:0] kdat = robust ? `RS_K_ROBUST : `RS_K_NORMAL;
	wire [4:0] twot = robust ? `RS_2T_ROBUST : `RS_2T_NORMAL;
	wire [127:0] gen = robust ? GEN_ROBUST : GEN_NORMAL;
	// header always six-fold; payload four-fold only in robust mode
	wire [2:0] reps = frame_control_header ? `REP_FCH : (robust ? `REP_ROBUST : `REP_NORMAL);
	wire [1:0] mlast = (modsel == `MOD_BIN) ? 2'h0 : ((modsel == `MOD_QUAD) ? 2'h1 : 2'h2);

	// a start with bad interleaver shifts is refused outright
	wire params_ok = coprime(mi, rows) && coprime(mj, rows) && coprime(ni, cols) &&
		coprime(nj, cols) && (rows != 8'h00) && (cols != 8'h00) &&
		(total <= `IL_MAX_BITS);
	wire start_go = reg_wr_in && (reg_addr_in == `ADDR_CTRL) && reg_wdata_in[`CTRL_START] &&
		(state == S_IDLE) && params_ok;
	assign byte_ready_out = (state == S_IN);

	// ----------------------------------------
	// datapath terms
	// ----------------------------------------
	wire [14:0] scr_res = scramble(byte_in, scr);
	wire [7:0] sbyte = scr_res[7:0];
	wire [7:0] rs_fb = sbyte ^ par[127:120];
	// newest input bit on top of the six remembered ones
	wire [6:0] win = {cur_byte[7], cs};
	wire cx = ^(win & `CONV_TAP_X);
	wire cy = ^(win & `CONV_TAP_Y);
	wire code_bit = pair ? cy : cx;
	// interleaver target: column first, then row from the shifted column
	wire [16:0] jsum = wj * nj + wi * ni;
	wire [16:0] cj = jsum % {9'h000, cols};
	wire [16:0] isum = wi * mi + cj[7:0] * mj;
	wire [16:0] ci = isum % {9'h000, rows};
	wire [15:0] wr_addr = cj[7:0] * rows + {8'h00, ci[7:0]};
	wire rbit = il_mem[rd_ptr[10:0]];
	wire out_free = ~map_valid_out | map_ready_in;

	// rs division step; leading zero bytes leave this all-zero state unchanged
	always @*
	begin
		next_par = {par[119:0], 8'h00};
		for (c = 0; c < 16; c = c + 1)
			next_par[8*c +: 8] = next_par[8*c +: 8] ^ gf_mul(gen[8*c +: 8], rs_fb);
	end

	// differential phase step in units of 45 degrees
	always @*
	begin
		vsym = acc;
		vsym[mcnt] = rbit;
		delta = 3'h0;
		case (modsel)
			`MOD_BIN: delta = vsym[0] ? 3'h4 : 3'h0;
			`MOD_QUAD:
				case (vsym[1:0])
					2'h0: delta = 3'h0;
					2'h1: delta = 3'h2;
					2'h3: delta = 3'h4;
					default: delta = 3'h6;
				endcase
			default:
				case (vsym)
					3'h0: delta = 3'h0;
					3'h1: delta = 3'h1;
					3'h5: delta = 3'h2;
					3'h7: delta = 3'h3;
					3'h3: delta = 3'h4;
					3'h2: delta = 3'h5;
					3'h6: delta = 3'h6;
					default: delta = 3'h7;
				endcase
		endcase
	end

	// ----------------------------------------
	// register port
	// ----------------------------------------
	// settings are frozen while a part is in flight
	always @(posedge mclk_in)
	begin
		if (!rst_n_in)
		begin
			ctrl <= `RST_CTRL;
			matrix <= `RST_MATRIX;
			shifts <= `RST_SHIFTS;
			tones <= `RST_TONES;
			reg_rdata_out <= 32'h00000000;
		end
		else
		begin
			if (reg_wr_in && state == S_IDLE)
			begin
				if (reg_addr_in == `ADDR_CTRL)
					ctrl <= {reg_wdata_in[4:1], 1'b0};
				else if (reg_addr_in == `ADDR_MATRIX)
					matrix <= reg_wdata_in[15:0];
				else if (reg_addr_in == `ADDR_SHIFTS)
					shifts <= reg_wdata_in;
				else if (reg_addr_in == `ADDR_TONES)
					tones <= reg_wdata_in;
			end
			reg_rdata_out <= 32'h00000000;
			if (reg_rd_in)
			begin
				if (reg_addr_in == `ADDR_CTRL)
					reg_rdata_out <= {27'h0000000, ctrl};
				else if (reg_addr_in == `ADDR_MATRIX)
					reg_rdata_out <= {16'h0000, matrix};
				else if (reg_addr_in == `ADDR_SHIFTS)
					reg_rdata_out <= shifts;
				else if (reg_addr_in == `ADDR_TONES)
					reg_rdata_out <= tones;
				else if (reg_addr_in == `ADDR_STATUS)
					reg_rdata_out <= {29'h0000000, done, params_ok, state != S_IDLE};
			end
		end
	end

	// ----------------------------------------
	// coding engine
	// ----------------------------------------
	// bit-serial: one coded bit per clock keeps the datapath small at the
	// cost of up to twelve clocks per input bit in header mode
	always @(posedge mclk_in)
	begin
		if (!rst_n_in)
		begin
			state <= S_IDLE;
			done <= 1'b0;
			scr <= `SCR_SEED;
			par <= 128'h0;
			cur_byte <= 8'h00;
			bits_left <= 4'h0;
			cs <= 6'h00;
			pair <= 1'b0;
			rep <= 3'h0;
			in_par <= 1'b0;
			in_tail <= 1'b0;
			src_last <= 1'b0;
			data_cnt <= 8'h00;
			par_left <= 5'h00;
			wi <= 8'h00;
			wj <= 8'h00;
			wr_full <= 1'b0;
			rd_ptr <= 16'h0000;
			car <= 5'h00;
			mcnt <= 2'h0;
			acc <= 3'h0;
			map_valid_out <= 1'b0;
			map_carrier_out <= 5'h00;
			map_phase_out <= 3'h0;
			for (pc = 0; pc < `NUM_CARRIERS; pc = pc + 1)
				ph[pc] <= 3'h0;
		end
		else
		begin
			if (map_valid_out && map_ready_in)
				map_valid_out <= 1'b0;
			case (state)
				S_IDLE:
					if (start_go)
					begin
						done <= 1'b0;
						scr <= `SCR_SEED;
						cs <= 6'h00;
						par <= 128'h0;
						pair <= 1'b0;
						rep <= 3'h0;
						in_par <= 1'b0;
						in_tail <= 1'b0;
						data_cnt <= 8'h00;
						wi <= 8'h00;
						wj <= 8'h00;
						wr_full <= 1'b0;
						// header takes the preamble reference; payload keeps header phases
						if (!reg_wdata_in[`CTRL_PART])
							for (pc = 0; pc < `NUM_CARRIERS; pc = pc + 1)
								ph[pc] <= 3'h0;
						state <= S_IN;
					end
				S_IN:
					if (byte_valid_in)
					begin
						scr <= scr_res[14:8];
						par <= next_par;
						cur_byte <= sbyte;
						bits_left <= 4'h8;
						src_last <= byte_last_in;
						data_cnt <= data_cnt + 8'h01;
						state <= S_BITS;
					end
				S_BITS:
				begin
					if (!wr_full)
						il_mem[wr_addr[10:0]] <= code_bit;
					if (!wr_full)
					begin
						wj <= (wj == cols - 8'h01) ? 8'h00 : wj + 8'h01;
						if (wj == cols - 8'h01)
						begin
							wi <= wi + 8'h01;
							wr_full <= (wi == rows - 8'h01);
						end
					end
					if (rep != reps - 3'h1)
						rep <= rep + 3'h1;
					else
					begin
						rep <= 3'h0;
						pair <= ~pair;
						if (pair)
						begin
							cs <= win[6:1];
							cur_byte <= {cur_byte[6:0], 1'b0};
							bits_left <= bits_left - 4'h1;
							if (bits_left == 4'h1)
								state <= S_NEXT;
						end
					end
				end
				S_NEXT:
					if (in_tail)
						state <= S_PAD;
					else if (in_par ? (par_left != 5'h00) : (src_last || data_cnt == kdat))
					begin
						// parity bytes leave highest first, 2t of them
						cur_byte <= par[127:120];
						par <= {par[119:0], 8'h00};
						par_left <= in_par ? par_left - 5'h01 : twot - 5'h01;
						in_par <= 1'b1;
						bits_left <= 4'h8;
						state <= S_BITS;
					end
					else if (src_last)
					begin
						in_tail <= 1'b1;
						cur_byte <= 8'h00;
						bits_left <= `TAIL_BITS;
						state <= S_BITS;
					end
					else
					begin
						in_par <= 1'b0;
						if (in_par)
							data_cnt <= 8'h00;
						state <= S_IN;
					end
				S_PAD:
					if (wr_full)
					begin
						rd_ptr <= 16'h0000;
						car <= 5'h00;
						mcnt <= 2'h0;
						acc <= 3'h0;
						state <= S_OUT;
					end
					else
					begin
						il_mem[wr_addr[10:0]] <= 1'b0;
						wj <= (wj == cols - 8'h01) ? 8'h00 : wj + 8'h01;
						if (wj == cols - 8'h01)
						begin
							wi <= wi + 8'h01;
							wr_full <= (wi == rows - 8'h01);
						end
					end
				S_OUT:
					if (out_free)
					begin
						if (rd_ptr == total)
						begin
							done <= 1'b1;
							state <= S_IDLE;
						end
						else if (!tones[car])
							car <= car + 5'h01;
						else
						begin
							acc <= vsym;
							rd_ptr <= rd_ptr + 16'h0001;
							if (mcnt == mlast)
							begin
								mcnt <= 2'h0;
								acc <= 3'h0;
								ph[car] <= ph[car] + delta;
								map_valid_out <= 1'b1;
								map_carrier_out <= car;
								map_phase_out <= ph[car] + delta;
								car <= car + 5'h01;
							end
							else
								mcnt <= mcnt + 2'h1;
						end
					end
				default:
					state <= S_IDLE;
			endcase
		end
	end
endmodule // fec_tx_chain

/* fec_tx_defs.vh */
// Purpose: constants for the transmit forward error correction chain
// Assumes: included by its bare name from the design file
// Notes: definitions only
`ifndef FEC_TX_DEFS_VH
`define FEC_TX_DEFS_VH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define ADDR_CTRL 4'h0
`define ADDR_MATRIX 4'h1
`define ADDR_SHIFTS 4'h2
`define ADDR_TONES 4'h3
`define ADDR_STATUS 4'h4
// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define CTRL_START 0
`define CTRL_PART 1
`define CTRL_ROBUST 2
`define CTRL_MOD_LO 3
`define CTRL_MOD_HI 4
`define STAT_BUSY 0
`define STAT_OK 1
`define STAT_DONE 2
`define RST_CTRL 5'h00
`define RST_MATRIX 16'h0000
`define RST_SHIFTS 32'h00000000
`define RST_TONES 32'hFFFFFFFF
// ----------------------------------------
// modulation codes
// ----------------------------------------
`define MOD_BIN 2'h0
`define MOD_QUAD 2'h1
`define MOD_EIGHT 2'h2
// ----------------------------------------
// coding constants
// ----------------------------------------
`define SCR_SEED 7'h7F
`define CONV_TAP_X 7'h79
`define CONV_TAP_Y 7'h5B
`define TAIL_BITS 4'h6
`define RS_K_NORMAL 8'hEF
`define RS_K_ROBUST 8'hF7
`define RS_2T_NORMAL 5'h10
`define RS_2T_ROBUST 5'h08
`define FIELD_POLY 9'h11D
`define REP_FCH 3'h6
`define REP_ROBUST 3'h4
`define REP_NORMAL 3'h1
`define IL_DEPTH 2048
`define IL_MAX_BITS 16'h0800
`define NUM_CARRIERS 32
`endif

/* fec_tx_chain_chk.sv */
// Purpose: port-level checks for the transmit fec chain
// Assumes: bound onto fec_tx_chain from the bench top file
// Notes: one clock domain, so default clocking and disable are used
`timescale 1ns/1ns
module fec_tx_chain_chk (
	// clock and reset
	input wire mclk_in,
	input wire rst_n_in,
	// register port
	input wire [3:0] reg_addr_in,
	input wire reg_rd_in,
	input wire [31:0] reg_rdata_out,
	// streams
	input wire byte_valid_in,
	input wire byte_ready_out,
	input wire map_valid_out,
	input wire [4:0] map_carrier_out,
	input wire [2:0] map_phase_out,
	input wire map_ready_in
);
	// ------
	// checks
	// ------
	default clocking dc @(posedge mclk_in);
	endclocking
	default disable iff (!rst_n_in);
	property p_reset_quiet;
		$past(rst_n_in) == 1'b0 |-> !byte_ready_out && !map_valid_out && reg_rdata_out == 32'h0;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active after reset");
	property p_rd_zero;
		!$past(reg_rd_in) |-> reg_rdata_out == 32'h0;
	endproperty
	a_rd_zero: assert property (p_rd_zero) else $error("read data outside its cycle");
	property p_unmapped;
		reg_rd_in && reg_addr_in > 4'h4 |=> reg_rdata_out == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped index read nonzero");
	property p_start_reads0;
		reg_rd_in && reg_addr_in == 4'h0 |=> reg_rdata_out[0] == 1'b0;
	endproperty
	a_start_reads0: assert property (p_start_reads0) else $error("start bit read back");
	// a byte expands to at least sixteen coded bits, one cycle each
	property p_byte_gap;
		byte_valid_in && byte_ready_out |=> !byte_ready_out [*8] ##1 !byte_ready_out [*8];
	endproperty
	a_byte_gap: assert property (p_byte_gap) else $error("byte taken too soon");
	property p_map_hold;
		map_valid_out && !map_ready_in |=> map_valid_out && $stable(map_carrier_out)
			&& $stable(map_phase_out);
	endproperty
	a_map_hold: assert property (p_map_hold) else $error("carrier output moved");
	// binary mode may offer the next carrier right after acceptance, so only
	// a repeat of the same carrier is an error (single-tone maps excepted)
	property p_map_gap;
		map_valid_out && map_ready_in |=> !map_valid_out ||
			map_carrier_out != $past(map_carrier_out);
	endproperty
	a_map_gap: assert property (p_map_gap) else $error("accepted carrier offered again");
	// the matrix is complete before any carrier is read out
	property p_fill_first;
		byte_ready_out |-> !map_valid_out;
	endproperty
	a_fill_first: assert property (p_fill_first) else $error("carrier while filling");
endmodule // fec_tx_chain_chk

/* fec_far_side.sv */
// Purpose: byte source ahead of the chain and carrier sink behind it
// Assumes: same clock as the chain; bench fills tx_q and drains rx_q
// Notes: the sink stalls at random so held outputs get exercised
`timescale 1ns/1ns
module fec_far_side (
	// clock
	input wire mclk_in,
	// byte source
	input wire byte_ready_in,
	output logic byte_valid_out,
	output logic [7:0] byte_out,
	output logic byte_last_out,
	// carrier sink
	input wire map_valid_in,
	input wire [4:0] map_carrier_in,
	input wire [2:0] map_phase_in,
	output logic map_ready_out
);
	logic [7:0] tx_q[$];
	logic [7:0] rx_q[$];
	// idle at time zero
	initial
	begin
		byte_valid_out = 1'b0;
		byte_out = 8'h00;
		byte_last_out = 1'b0;
		map_ready_out = 1'b0;
	end
	// hold a byte until taken; a released bus inverts every cycle, so it shows the stale byte every other cycle
	always @(posedge mclk_in)
	begin
		if (byte_valid_out && byte_ready_in)
			void'(tx_q.pop_front());
		if (tx_q.size() != 0)
		begin
			byte_valid_out <= 1'b1;
			byte_out <= tx_q[0];
			byte_last_out <= tx_q.size() == 1;
		end
		else
		begin
			byte_valid_out <= 1'b0;
			byte_out <= ~byte_out;
			byte_last_out <= 1'b0;
		end
	end
	// collect accepted carriers, stalling about a third of the time
	always @(posedge mclk_in)
	begin
		if (map_valid_in && map_ready_out)
			rx_q.push_back({map_phase_in, map_carrier_in});
		map_ready_out <= ($urandom % 3) != 0;
	end
endmodule // fec_far_side

/* fec_tx_chain_test.sv */
// Purpose: self-checking bench for the transmit fec chain
// Assumes: far side in fec_far_side.sv, checker in fec_tx_chain_chk.sv
// Notes: bit-level reference model built from integers and queues
`timescale 1ns/1ns
module fec_tx_chain_test;
	logic mclk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic [3:0] reg_addr_in = 4'h0;
	logic [31:0] reg_wdata_in = 32'h0;
	logic reg_wr_in = 1'b0;
	logic reg_rd_in = 1'b0;
	logic [31:0] rv;
	logic [31:0] tones;
	wire [31:0] reg_rdata_out;
	wire byte_valid_in, byte_last_in, byte_ready_out, map_valid_out, map_ready_in;
	wire [7:0] byte_in;
	wire [4:0] map_carrier_out;
	wire [2:0] map_phase_out;
	int fail_count = 0;
	int cmp_count = 0;
	int part, rob, md, m, n, mi, mj, ni, nj, st, rep;
	int done_f = 0;
	int dq[$], cb[$], exp_q[$];
	int ph[32];
	// ------
	// units
	// ------
	fec_tx_chain u_dut (
		.mclk_in(mclk_in),
		.rst_n_in(rst_n_in),
		.reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in),
		.reg_wr_in(reg_wr_in),
		.reg_rd_in(reg_rd_in),
		.reg_rdata_out(reg_rdata_out),
		.byte_valid_in(byte_valid_in),
		.byte_in(byte_in),
		.byte_last_in(byte_last_in),
		.byte_ready_out(byte_ready_out),
		.map_valid_out(map_valid_out),
		.map_carrier_out(map_carrier_out),
		.map_phase_out(map_phase_out),
		.map_ready_in(map_ready_in)
	);
	fec_far_side u_far (
		.mclk_in(mclk_in),
		.byte_ready_in(byte_ready_out),
		.byte_valid_out(byte_valid_in),
		.byte_out(byte_in),
		.byte_last_out(byte_last_in),
		.map_valid_in(map_valid_out),
		.map_carrier_in(map_carrier_out),
		.map_phase_in(map_phase_out),
		.map_ready_out(map_ready_in)
	);
	// 10 MHz clock
	initial
	begin
		forever #50 mclk_in = ~mclk_in;
	end
	// galois multiply, reduced by the field polynomial
	function automatic int gm(int a, int b);
		int r = 0;
		repeat (8)
		begin
			if (b & 1)
				r ^= a;
			b >>= 1;
			a = (a << 1 ^ (a >> 7 & 1) * 9'h11D) & 255;
		end
		return r;
	endfunction
	// one convolutional step, each output repeated rep times
	task automatic cbit(input int b);
		int w;
		w = b << 6 | st;
		repeat (rep)
			cb.push_back($countones(w & 7'h79) & 1);
		repeat (rep)
			cb.push_back($countones(w & 7'h5B) & 1);
		st = w >> 1;
	endtask
	task automatic cbyte(input int d);
		for (int i = 7; i >= 0; i--)
			cbit(d >> i & 1);
	endtask
	// reference: expected {phase, carrier} for the queued bytes
	task automatic model();
		int s, d, fb, t2, kk, c, a, v, x, car, tbl;
		int g[$];
		int p[16];
		int il[2048];
		s = 127;
		st = 0;
		c = 0;
		cb = {};
		exp_q = {};
		p = '{default: 0};
		t2 = rob ? 8 : 16;
		kk = rob ? 247 : 239;
		rep = part ? (rob ? 4 : 1) : 6;
		g = {1};
		a = 2;
		repeat (t2)
		begin
			g.push_front(0);
			for (int k = 0; k < g.size() - 1; k++)
				g[k] ^= gm(a, g[k + 1]);
			a = gm(a, 2);
		end
		foreach (dq[j])
		begin
			d = 0;
			for (int i = 7; i >= 0; i--)
			begin
				fb = (s >> 6 ^ s >> 3) & 1;
				s = (s << 1 | fb) & 127;
				d |= (dq[j] >> i & 1 ^ fb) << i;
			end
			cbyte(d);
			fb = d ^ p[t2 - 1];
			for (int k = t2 - 1; k > 0; k--)
				p[k] = p[k - 1] ^ gm(fb, g[k]);
			p[0] = gm(fb, g[0]);
			c++;
			if (c == kk || j == dq.size() - 1)
			begin
				for (int k = t2 - 1; k >= 0; k--)
					cbyte(p[k]);
				p = '{default: 0};
				c = 0;
			end
		end
		repeat (6)
			cbit(0);
		for (int k = 0; k < m * n; k++)
		begin
			x = (k % n * nj + k / n * ni) % n;
			v = (k / n * mi + x * mj) % m;
			il[x * m + v] = k < cb.size() ? cb[k] : 0;
		end
		if (!part)
			ph = '{default: 0};
		tbl = md == 0 ? 32'h40 : md == 1 ? 32'h4620 : 32'h36274510;
		car = 31;
		for (x = 0; x + md + 1 <= m * n; x += md + 1)
		begin
			v = 0;
			for (int b = 0; b <= md; b++)
				v |= il[x + b] << b;
			car = (car + 1) % 32;
			while (!tones[car])
				car = (car + 1) % 32;
			ph[car] = (ph[car] + (tbl >> 4 * v & 15)) % 8;
			exp_q.push_back(ph[car] << 5 | car);
		end
	endtask
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= 1'b1;
		@(posedge mclk_in);
		reg_wr_in <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge mclk_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge mclk_in);
		reg_rd_in <= 1'b0;
		@(negedge mclk_in);
		d = reg_rdata_out;
	endtask
	// one frame part with random shifts, tones and bytes
	task automatic frame(input int pt, rb, mo, mm, nn, nb);
		logic [31:0] v;
		part = pt;
		rob = rb;
		md = mo;
		m = mm;
		n = nn;
		mi = 1 + $urandom % (m - 1);
		mj = 1 + $urandom % (m - 1);
		ni = 1 + $urandom % (n - 1);
		nj = 1 + $urandom % (n - 1);
		tones = $urandom | 32'h1;
		wr(1, n << 8 | m);
		wr(2, nj << 24 | ni << 16 | mj << 8 | mi);
		wr(3, tones);
		rd(4, v);
		chk("status", v, done_f << 2 | 2);
		dq = {};
		repeat (nb)
			dq.push_back($urandom & 255);
		model();
		foreach (dq[i])
			u_far.tx_q.push_back(dq[i]);
		wr(0, md << 3 | rob << 2 | part << 1 | 1);
		wr(1, 32'h0);
		foreach (exp_q[i])
		begin
			for (int w = 0; w < 4000 && u_far.rx_q.size() == 0; w++)
				@(posedge mclk_in);
			chk("map", u_far.rx_q.pop_front(), exp_q[i]);
		end
		v = 32'h1;
		for (int w = 0; w < 100 && v[0] !== 1'b0; w++)
			rd(4, v);
		chk("done", v, 32'h6);
		rd(1, v);
		chk("matrix", v, n << 8 | m);
		chk("extra carriers", u_far.rx_q.size(), 0);
		chk("bytes left", u_far.tx_q.size(), 0);
		done_f = 1;
	endtask
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// watchdog well beyond the expected few thousand cycles
	initial
	begin
		repeat (60000)
			@(posedge mclk_in);
		fail_count++;
		stop_test();
	end
	// main sequence
	initial
	begin
		void'($urandom(32'hBA32));
		repeat (8)
			@(posedge mclk_in);
		rst_n_in <= 1'b1;
		for (int a = 0; a < 6; a++)
		begin
			rd(a, rv);
			chk("reg", rv, a == 3 ? 32'hFFFFFFFF : 32'h0);
		end
		wr(1, 32'h0406);
		wr(2, 32'h01010102);
		wr(0, 32'h1);
		rd(4, rv);
		chk("refused", rv, 32'h0);
		$display("test 1 done");
		frame(0, 0, 1, 7, 11, 2);
		$display("test 2 done");
		frame(1, 1, 2, 13, 5, 3);
		$display("test 3 done");
		frame(1, 0, 0, 17, 19, 1);
		$display("test 4 done");
		stop_test();
	end
endmodule // fec_tx_chain_test
bind fec_tx_chain fec_tx_chain_chk u_chk (
	.mclk_in(mclk_in),
	.rst_n_in(rst_n_in),
	.reg_addr_in(reg_addr_in),
	.reg_rd_in(reg_rd_in),
	.reg_rdata_out(reg_rdata_out),
	.byte_valid_in(byte_valid_in),
	.byte_ready_out(byte_ready_out),
	.map_valid_out(map_valid_out),
	.map_carrier_out(map_carrier_out),
	.map_phase_out(map_phase_out),
	.map_ready_in(map_ready_in)
);
